// file: design/scg_audio_clock_gen.sv
// audio clock generator: divider registers, clock chain, frame timing, bus slave
// How it works
// (R01) with audio clock select set, the divider register picks the clock source
// (R02) nonzero serial clock rate: bit clock from core divider, no phase tie
// (R03) system clock equals selected source divided by selected power of two
// (R04) rate zero with select set: bit clock is system clock divided by 8, 4 or 1
// (R05) frame rate is bit clock over sample width, times slot count only with the net bit set
// (R06) software should change the divider only while the port is off
// (R07) source codes 0..5 pick fixed sources, 6 dither, 7 reserved
// (R08) source code 6 routes the dither divider into the power-of-two divider
// (R09) divider codes 0..5 divide by 1 to 32, 6 and 7 reserved
// (R10) select set, divide-by-eight set, bypass clear: divide by 8
// (R11) select set, divide-by-eight and bypass clear: divide by 4
// (R12) select and bypass set: system clock passes undivided
// (R13) select clear: divide-by-eight and bypass have no effect
// (R14) rate zero and audio path: audio clock drives the bit clock
// (R15) software keeps audio clock select clear in ring oscillator mode
// (R16) software avoids source 4 with divisor 1, source 5 with 1 or 2
// (R17) dither divider uses 15-bit numerator and 12-bit denominator
// (R18) software writes zero to reserved bits, reads them as undefined
// (R19) divider fields at bits 7, 6:4, 3, 2:0, all reset to zero
// (R20) software uses the recommended settings for standard frame rates
// (R21) setting changes are applied glitch-free, never shortening a pulse; the code emits a one-cycle pulse if a divider level rises in the swap cycle
`timescale 1ns/100ps
module scg_audio_clock_gen (
    input  wire logic        i_core_clk,
    input  wire logic        i_arst_n,
    input  wire logic [5:0]  i_source_tick,
    input  wire logic        i_pll_tick,
    input  wire logic        i_axi_awvalid,
    output logic             o_axi_awready,
    input  wire logic [7:0]  i_axi_awaddr,
    input  wire logic        i_axi_wvalid,
    output logic             o_axi_wready,
    input  wire logic [31:0] i_axi_wdata,
    input  wire logic [3:0]  i_axi_wstrb,
    output logic             o_axi_bvalid,
    input  wire logic        i_axi_bready,
    output logic [1:0]       o_axi_bresp,
    input  wire logic        i_axi_arvalid,
    output logic             o_axi_arready,
    input  wire logic [7:0]  i_axi_araddr,
    output logic             o_axi_rvalid,
    input  wire logic        i_axi_rready,
    output logic [31:0]      o_axi_rdata,
    output logic [1:0]       o_axi_rresp,
    output logic             o_system_clock_out,
    output logic             o_serial_bit_clock,
    output logic             o_frame_signal
);
`include "scg_map.svh"

    // ----------------------------------------------------------------
    // reset release
    // ----------------------------------------------------------------
    logic [1:0] rst_q;
    logic       rst_n;

    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rst_q <= 2'h0;
        end else begin
            rst_q <= {rst_q[0], 1'b1};
        end
    end
    assign rst_n = rst_q[1];

    // ----------------------------------------------------------------
    // active configuration
    // ----------------------------------------------------------------
    scg_pkg::scg_state_s s;
    scg_pkg::scg_state_s n;
    scg_pkg::scg_pre_e   pre_mode;
    logic                act_en;
    logic                act_acs;
    logic                act_net;
    logic                act_byp;
    logic                act_x8;
    logic [4:0]          act_wid;
    logic [2:0]          act_slot;
    logic [11:0]         act_scr;
    logic [2:0]          act_src;
    logic [2:0]          act_div;
    logic [14:0]         act_num;
    logic [11:0]         act_den;
    logic                audio;
    logic                pending;
    logic                apply;
    logic [2:0]          dsel;
    logic [5:0]          pow_half;
    logic [2:0]          pre_half;
    logic                sel_tick;
    logic                pow_clr;
    logic                pre_clr;
    logic                scr_clr;
    logic                sys_lvl;
    logic                sys_tgl;
    logic                pre_lvl;
    logic                pre_tgl;
    logic                scr_lvl;
    logic                scr_tgl;
    logic                bit_lvl;
    logic                bit_tgl;
    logic [9:0]          flen_m1;
    logic [15:0]         dsum;

    assign act_en   = s.act_ctl[`SCG_EN_BIT];
    assign act_acs  = s.act_ctl[`SCG_ACS_BIT];
    assign act_net  = s.act_ctl[`SCG_NET_BIT];
    assign act_wid  = s.act_ctl[`SCG_WID_LSB +: 5];
    assign act_slot = s.act_ctl[`SCG_SLOT_LSB +: 3];
    assign act_scr  = s.act_ctl[`SCG_SCR_LSB +: 12];
    assign act_div  = s.act_acd[`SCG_DIV_LSB +: 3];
    assign act_byp  = s.act_acd[`SCG_BYP_BIT];
    assign act_src  = s.act_acd[`SCG_SRC_LSB +: 3];
    assign act_x8   = s.act_acd[`SCG_X8_BIT];
    assign act_num  = s.act_acdd[`SCG_NUM_LSB +: 15];
    assign act_den  = s.act_acdd[`SCG_DEN_LSB +: 12];

    // audio path only when select is set and the rate field is zero
    assign audio   = act_acs && (act_scr == 12'h000); // see (R14)
    assign pending = (s.ctl != s.act_ctl) || (s.acd != s.act_acd) || (s.acdd != s.act_acdd);
    // swap only while both clocks sit low; counters restart low, yet a divider level that rose in the swap cycle still gives a one-cycle runt pulse
    assign apply   = pending && !s.sys_out && !s.bit_out; // see (R21)

    // ----------------------------------------------------------------
    // source selection and dividers
    // ----------------------------------------------------------------
    always_comb begin
        sel_tick = 1'b0;
        if (act_acs) begin // see (R01)
            if (act_src == `SCG_SRC_DITHER) begin
                sel_tick = s.dtick; // see (R08)
            end else if (act_src < `SCG_SRC_DITHER) begin
                sel_tick = i_source_tick[act_src]; // see (R07)
            end
        end
    end

    // reserved divider codes fall back to the largest divisor
    assign dsel     = (act_div > `SCG_DIV_MAX) ? `SCG_DIV_MAX : act_div; // see (R09)
    assign pow_half = (6'h1 << dsel) - 6'h1; // see (R03)
    assign pre_mode = act_byp ? scg_pkg::SCG_PRE_BYP :
                      (act_x8 ? scg_pkg::SCG_PRE_DIV8 : scg_pkg::SCG_PRE_DIV4);

    always_comb begin
        case (pre_mode)
            scg_pkg::SCG_PRE_BYP: begin
                pre_half = `SCG_HALF_BYP; // see (R12)
            end
            scg_pkg::SCG_PRE_DIV8: begin
                pre_half = `SCG_HALF_DIV8; // see (R10)
            end
            default: begin
                pre_half = `SCG_HALF_DIV4; // see (R11)
            end
        endcase
    end

    // with select clear the prescaler is held, so its mode bits do nothing
    assign pow_clr = !act_acs || apply;
    assign pre_clr = !act_acs || !act_en || apply; // see (R13)
    assign scr_clr = !act_en || apply;

    scg_tick_div #(.W(6)) u_pow (
        .i_core_clk (i_core_clk),
        .i_rst_n    (rst_n),
        .i_tick     (sel_tick),
        .i_clear    (pow_clr),
        .i_half     (pow_half),
        .o_level    (sys_lvl),
        .o_toggle   (sys_tgl)
    );

    scg_tick_div #(.W(3)) u_pre (
        .i_core_clk (i_core_clk),
        .i_rst_n    (rst_n),
        .i_tick     (sys_tgl),
        .i_clear    (pre_clr),
        .i_half     (pre_half),
        .o_level    (pre_lvl),
        .o_toggle   (pre_tgl)
    );

    // core-clock divider is independent of the audio chain: no phase relation
    scg_tick_div #(.W(12)) u_scr (
        .i_core_clk (i_core_clk),
        .i_rst_n    (rst_n),
        .i_tick     (1'b1),
        .i_clear    (scr_clr),
        .i_half     (act_scr),
        .o_level    (scr_lvl),
        .o_toggle   (scr_tgl)
    );

    assign bit_lvl = audio ? pre_lvl : scr_lvl; // see (R04) see (R02)
    assign bit_tgl = audio ? pre_tgl : scr_tgl;
    assign flen_m1 = (10'(act_wid) + 10'h1) * (act_net ? 10'(act_slot) + 10'h1 : 10'h1)
                     - 10'h1;

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        n = s;
        n.dtick = 1'b0;
        dsum = {1'b0, s.acc} + 16'(act_den);
        // fractional accumulator: one tick per pll tick at rate den/num
        if (apply) begin
            n.acc = '0;
        end else if (act_acs && act_src == `SCG_SRC_DITHER && i_pll_tick && act_num != 15'h0) begin
            if (dsum >= {1'b0, act_num}) begin // see (R17)
                n.acc = 15'(dsum - {1'b0, act_num});
                n.dtick = 1'b1;
            end else begin
                n.acc = dsum[14:0];
            end
        end
        n.sys_out = act_acs && sys_lvl;
        n.bit_out = act_en && bit_lvl;
        if (!act_en || apply) begin
            n.fcnt = '0;
            n.frame_out = 1'b0;
        end else if (bit_tgl && bit_lvl) begin
            n.frame_out = (s.fcnt == 10'h0); // see (R05)
            n.fcnt = (s.fcnt >= flen_m1) ? 10'h0 : s.fcnt + 10'h1;
        end
        if (apply) begin
            n.act_ctl = s.ctl;
            n.act_acd = s.acd;
            n.act_acdd = s.acdd;
        end
        // write channel: address and data in either order
        if (i_axi_awvalid && s.awready) begin
            n.aw_have = 1'b1;
            n.awaddr = i_axi_awaddr;
        end
        if (i_axi_wvalid && s.wready) begin
            n.w_have = 1'b1;
            n.wdata = i_axi_wdata;
            n.wstrb = i_axi_wstrb;
        end
        if (s.bvalid && i_axi_bready) begin
            n.bvalid = 1'b0;
        end
        if (s.aw_have && s.w_have) begin
            n.aw_have = 1'b0;
            n.w_have = 1'b0;
            n.bvalid = 1'b1;
            n.bresp = `SCG_RESP_OKAY;
            case (s.awaddr)
                `SCG_CTL_OFS: begin
                    n.ctl = scg_pkg::scg_merge(s.ctl, s.wdata, s.wstrb) & `SCG_CTL_MASK;
                end
                `SCG_ACD_OFS: begin
                    n.acd = scg_pkg::scg_merge(s.acd, s.wdata, s.wstrb)
                            & `SCG_ACD_MASK; // see (R19)
                end
                `SCG_ACDD_OFS: begin
                    n.acdd = scg_pkg::scg_merge(s.acdd, s.wdata, s.wstrb) & `SCG_ACDD_MASK;
                end
                `SCG_STAT_OFS: begin
                    n.bresp = `SCG_RESP_OKAY;
                end
                default: begin
                    n.bresp = `SCG_RESP_SLVERR;
                end
            endcase
        end
        n.awready = !n.aw_have && !n.bvalid;
        n.wready = !n.w_have && !n.bvalid;
        // read channel
        if (s.rvalid && i_axi_rready) begin
            n.rvalid = 1'b0;
        end
        if (i_axi_arvalid && s.arready) begin
            n.rvalid = 1'b1;
            n.rresp = `SCG_RESP_OKAY;
            case (i_axi_araddr)
                `SCG_CTL_OFS: begin
                    n.rdata = s.ctl;
                end
                `SCG_ACD_OFS: begin
                    n.rdata = s.acd;
                end
                `SCG_ACDD_OFS: begin
                    n.rdata = s.acdd;
                end
                `SCG_STAT_OFS: begin
                    n.rdata = {18'h0, s.fcnt, pending, s.frame_out, s.bit_out, s.sys_out};
                end
                default: begin
                    n.rdata = 32'h0000_0000;
                    n.rresp = `SCG_RESP_SLVERR;
                end
            endcase
        end
        n.arready = !n.rvalid;
    end

    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign o_axi_awready      = s.awready;
    assign o_axi_wready       = s.wready;
    assign o_axi_bvalid       = s.bvalid;
    assign o_axi_bresp        = s.bresp;
    assign o_axi_arready      = s.arready;
    assign o_axi_rvalid       = s.rvalid;
    assign o_axi_rdata        = s.rdata;
    assign o_axi_rresp        = s.rresp;
    assign o_system_clock_out = s.sys_out;
    assign o_serial_bit_clock = s.bit_out;
    assign o_frame_signal     = s.frame_out;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    logic [6:0] h_pow;
    logic [3:0] h_pre;

    // tick counts between divider toggles
    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            h_pow <= 7'h00;
            h_pre <= 4'h0;
        end else begin
            h_pow <= (pow_clr || sys_tgl) ? {6'h00, sel_tick && !pow_clr}
                                          : h_pow + {6'h00, sel_tick};
            h_pre <= (pre_clr || pre_tgl) ? {3'h0, sys_tgl && !pre_clr} : h_pre + {3'h0, sys_tgl};
        end
    end

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!rst_n);

    property p_r13;
        !act_acs |=> !o_system_clock_out;
    endproperty
    a_r13: assert property (p_r13) else $error("system clock runs with select clear"); // see (R13)
    property p_r07;
        act_acs && act_src < `SCG_SRC_DITHER |-> sel_tick == i_source_tick[act_src];
    endproperty
    a_r07: assert property (p_r07) else $error("wrong fixed source selected"); // see (R07)
    property p_r08;
        act_acs && act_src == `SCG_SRC_DITHER
            |-> sel_tick == s.dtick && (!s.dtick || $past(i_pll_tick));
    endproperty
    a_r08: assert property (p_r08) else $error("dither output not routed"); // see (R08)
    property p_r09;
        sys_tgl && !$past(pow_clr) |-> h_pow == (7'h1 << dsel);
    endproperty
    a_r09: assert property (p_r09) else $error("power-of-two divide wrong"); // see (R09)
    property p_r10;
        pre_tgl && act_x8 && !act_byp |-> h_pre == 4'h8;
    endproperty
    a_r10: assert property (p_r10) else $error("divide by eight wrong"); // see (R10)
    property p_r11;
        pre_tgl && !act_x8 && !act_byp |-> h_pre == 4'h4;
    endproperty
    a_r11: assert property (p_r11) else $error("divide by four wrong"); // see (R11)
    property p_r12;
        act_acs && act_en && act_byp && sys_tgl && !pending |=> pre_tgl;
    endproperty
    a_r12: assert property (p_r12) else $error("bypass did not pass clock"); // see (R12)
    property p_r14;
        act_en && audio && !apply |=> o_serial_bit_clock == $past(pre_lvl);
    endproperty
    a_r14: assert property (p_r14) else $error("bit clock not from audio path"); // see (R14)
    property p_r02;
        $changed(o_serial_bit_clock) && act_en && !audio && !$past(apply)
            |-> $past(scr_lvl) == o_serial_bit_clock;
    endproperty
    a_r02: assert property (p_r02) else $error("bit clock not from rate divider"); // see (R02)
    property p_r05;
        $rose(o_frame_signal) |-> $rose(o_serial_bit_clock);
    endproperty
    a_r05: assert property (p_r05) else $error("frame not on bit clock rise"); // see (R05)
    property p_r21;
        // a write landing in the swap cycle stays pending, so check what was taken
        apply |-> !o_system_clock_out && !o_serial_bit_clock
                  ##1 s.act_ctl == $past(s.ctl) && s.act_acd == $past(s.acd)
                      && s.act_acdd == $past(s.acdd);
    endproperty
    a_r21: assert property (p_r21) else $error("setting applied mid pulse"); // see (R21)
    property p_r19;
        $rose(rst_n) |-> s.acd == `SCG_RST_VAL;
    endproperty
    a_r19: assert property (p_r19) else $error("divider register not reset"); // see (R19)

    property p_cov_byp;
        act_byp && pre_tgl;
    endproperty
    c_byp: cover property (p_cov_byp);
    property p_cov_dith;
        act_acs && act_src == `SCG_SRC_DITHER && sys_tgl;
    endproperty
    c_dith: cover property (p_cov_dith);
    property p_cov_frame;
        act_net && $rose(o_frame_signal);
    endproperty
    c_frame: cover property (p_cov_frame);
endmodule

// file: design/scg_map.svh
// register offsets, field positions and codes of the audio clock generator
`ifndef SCG_MAP_SVH
`define SCG_MAP_SVH
`define SCG_CTL_OFS     8'h00
`define SCG_ACD_OFS     8'h3c
`define SCG_ACDD_OFS    8'h40
`define SCG_STAT_OFS    8'h44
`define SCG_CTL_MASK    32'h00ff_fff7
`define SCG_ACD_MASK    32'h0000_00ff
`define SCG_ACDD_MASK   32'h0fff_7fff
`define SCG_RST_VAL     32'h0000_0000
`define SCG_EN_BIT      0
`define SCG_ACS_BIT     1
`define SCG_NET_BIT     2
`define SCG_WID_LSB     4
`define SCG_SLOT_LSB    9
`define SCG_SCR_LSB     12
`define SCG_DIV_LSB     0
`define SCG_BYP_BIT     3
`define SCG_SRC_LSB     4
`define SCG_X8_BIT      7
`define SCG_NUM_LSB     0
`define SCG_DEN_LSB     16
`define SCG_SRC_DITHER  3'h6
`define SCG_DIV_MAX     3'h5
`define SCG_HALF_DIV4   3'h3
`define SCG_HALF_DIV8   3'h7
`define SCG_HALF_BYP    3'h0
`define SCG_RESP_OKAY   2'h0
`define SCG_RESP_SLVERR 2'h2
`endif

// file: design/scg_pkg.sv
// shared types of the audio clock generator
package scg_pkg;
    typedef enum logic [1:0] {
        SCG_PRE_DIV4 = 2'h0,
        SCG_PRE_DIV8 = 2'h1,
        SCG_PRE_BYP  = 2'h3
    } scg_pre_e;

    typedef struct packed {
        logic [31:0] ctl;
        logic [31:0] acd;
        logic [31:0] acdd;
        logic [31:0] act_ctl;
        logic [31:0] act_acd;
        logic [31:0] act_acdd;
        logic [14:0] acc;
        logic        dtick;
        logic [9:0]  fcnt;
        logic        sys_out;
        logic        bit_out;
        logic        frame_out;
        logic        aw_have;
        logic        w_have;
        logic [7:0]  awaddr;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } scg_state_s;

    function automatic logic [31:0] scg_merge(input logic [31:0] o, input logic [31:0] d,
                                              input logic [3:0] b);
        logic [31:0] r;
        r = o;
        for (int i = 0; i < 4; i++) begin
            if (b[i]) begin
                r[8*i +: 8] = d[8*i +: 8];
            end
        end
        return r;
    endfunction
endpackage

// file: design/scg_tick_div.sv
// tick divider: toggles a level once every (half+1) input ticks
`timescale 1ns/100ps
module scg_tick_div #(
    parameter int W = 6
) (
    input  wire logic         i_core_clk,
    input  wire logic         i_rst_n,
    input  wire logic         i_tick,
    input  wire logic         i_clear,
    input  wire logic [W-1:0] i_half,
    output logic              o_level,
    output logic              o_toggle
);
    typedef struct packed {
        logic [W-1:0] cnt;
        logic         lvl;
        logic         tgl;
    } scg_div_s;

    scg_div_s s;
    scg_div_s n;

    always_comb begin
        n = s;
        n.tgl = 1'b0;
        if (i_clear) begin
            // clear parks the level low, so a pending low phase only grows
            n.cnt = '0;
            n.lvl = 1'b0;
        end else if (i_tick) begin
            if (s.cnt >= i_half) begin
                n.cnt = '0;
                n.lvl = !s.lvl;
                n.tgl = 1'b1;
            end else begin
                n.cnt = s.cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign o_level  = s.lvl;
    assign o_toggle = s.tgl;
endmodule

// file: testbench/scg_codec_model.sv
// codec-side model: times the received clocks in core cycles and counts bit clocks per frame
`timescale 1ns/100ps
module scg_codec_model (
    input  wire logic i_core_clk,
    input  wire logic i_system_clock,
    input  wire logic i_bit_clock,
    input  wire logic i_frame,
    output int        o_sys_period,
    output int        o_bit_period,
    output int        o_frame_bits
);
    // ----------------------------------------
    // edge timing
    // ----------------------------------------
    // a codec only sees edges, so periods are rise to rise; sampled on the
    // falling core edge where the registered clock outputs have settled
    int   now    = 0;
    int   t_sys  = 0;
    int   t_bit  = 0;
    int   nbits  = 0;
    logic s_q    = 1'b0;
    logic b_q    = 1'b0;
    logic f_q    = 1'b0;
    always @(negedge i_core_clk) begin
        now++;
        if (i_system_clock && !s_q) begin
            o_sys_period = now - t_sys;
            t_sys = now;
        end
        if (i_bit_clock && !b_q) begin
            o_bit_period = now - t_bit;
            t_bit = now;
            nbits++;
        end
        if (i_frame && !f_q) begin
            o_frame_bits = nbits;
            nbits = 0;
        end
        s_q = i_system_clock;
        b_q = i_bit_clock;
        f_q = i_frame;
    end
endmodule

// file: testbench/tb_scg_audio_clock_gen.sv
// testbench of the audio clock generator: register bus, clock chain, frames
`timescale 1ns/100ps
`include "scg_map.svh"
module tb_scg_audio_clock_gen;
    // ----------------------------------------
    // stimulus and observation
    // ----------------------------------------
    logic        clk   = 1'b0;
    logic        rst_n = 1'b0;
    logic        awv   = 1'b0;
    logic        wv    = 1'b0;
    logic        bry   = 1'b0;
    logic        arv   = 1'b0;
    logic        rry   = 1'b0;
    logic        pll   = 1'b0;
    logic [7:0]  awa   = 8'h00;
    logic [7:0]  ara   = 8'h00;
    logic [31:0] wd    = 32'h0000_0000;
    logic [3:0]  ws    = 4'h0;
    logic [5:0]  tick  = 6'h00;
    logic        awr, wr, bv, arr, rv, sysc, bitc, frm, hi;
    logic [1:0]  br, rr, resp;
    logic [31:0] rd, rdat;
    int          n_mismatch = 0;
    int          num_checks = 0;
    int          cnt [6] = '{default: 0};
    int          sp, bp, fb;

    always #20 clk = ~clk;
    // source k ticks every k+2 cycles, so each source has its own period
    always @(posedge clk) begin
        pll <= 1'b1; // pll always runs, no ring oscillator mode
        for (int k = 0; k < 6; k++) begin
            cnt[k] <= (cnt[k] == k + 1) ? 0 : cnt[k] + 1;
            tick[k] <= (cnt[k] == k + 1);
        end
    end

    scg_audio_clock_gen u_scg_audio_clock_gen (
        .i_core_clk(clk), .i_arst_n(rst_n), .i_source_tick(tick), .i_pll_tick(pll),
        .i_axi_awvalid(awv), .o_axi_awready(awr), .i_axi_awaddr(awa),
        .i_axi_wvalid(wv), .o_axi_wready(wr), .i_axi_wdata(wd), .i_axi_wstrb(ws),
        .o_axi_bvalid(bv), .i_axi_bready(bry), .o_axi_bresp(br),
        .i_axi_arvalid(arv), .o_axi_arready(arr), .i_axi_araddr(ara),
        .o_axi_rvalid(rv), .i_axi_rready(rry), .o_axi_rdata(rd), .o_axi_rresp(rr),
        .o_system_clock_out(sysc), .o_serial_bit_clock(bitc), .o_frame_signal(frm)
    );
    scg_codec_model u_scg_codec_model (
        .i_core_clk(clk), .i_system_clock(sysc), .i_bit_clock(bitc), .i_frame(frm),
        .o_sys_period(sp), .o_bit_period(bp), .o_frame_bits(fb)
    );

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // ready is registered, so it is looked at on the falling edge before the handshake
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        logic ah, wh;
        @(posedge clk);
        awv <= 1'b1; awa <= a; wv <= 1'b1; wd <= d; ws <= 4'hf; bry <= 1'b1;
        while (awv || wv) begin
            @(negedge clk);
            ah = awv & awr;
            wh = wv & wr;
            @(posedge clk);
            if (ah) awv <= 1'b0;
            if (wh) wv <= 1'b0;
        end
        do begin
            @(negedge clk);
            ah = bv;
            resp = br;
            @(posedge clk);
        end while (!ah);
        bry <= 1'b0;
    endtask

    task automatic axr(input logic [7:0] a);
        logic h;
        @(posedge clk);
        arv <= 1'b1; ara <= a; rry <= 1'b1;
        do begin
            @(negedge clk);
            h = arr;
            @(posedge clk);
        end while (!h);
        arv <= 1'b0;
        do begin
            @(negedge clk);
            h = rv;
            rdat = rd;
            resp = rr;
            @(posedge clk);
        end while (!h);
        rry <= 1'b0;
    endtask

    function automatic logic [31:0] ctl_of(input logic audio_clock_select, input int wid, input int slt,
                                           input int rate, input logic net);
        return 32'h1 | (32'(audio_clock_select) << `SCG_ACS_BIT) | (32'(net) << `SCG_NET_BIT)
             | (32'(wid - 1) << `SCG_WID_LSB) | (32'(slt - 1) << `SCG_SLOT_LSB)
             | (32'(rate) << `SCG_SCR_LSB);
    endfunction

    function automatic logic [31:0] acd_of(input logic x8, input int src, input logic byp,
                                           input int dv);
        return (32'(x8) << `SCG_X8_BIT) | (32'(src) << `SCG_SRC_LSB)
             | (32'(byp) << `SCG_BYP_BIT) | 32'(dv);
    endfunction

    task automatic cfg(input logic [31:0] ctl, input logic [31:0] acd);
        axw(`SCG_CTL_OFS, ctl & 32'hffff_fffe);
        axw(`SCG_ACD_OFS, acd);
        axw(`SCG_CTL_OFS, ctl);
    endtask

    task automatic expect_clk(input int s, input int b, input int f);
        repeat (3 * b * f + 200) @(posedge clk);
        chk("system clock period", sp, s);
        chk("bit clock period", bp, b);
        chk("bits per frame", fb, f);
    endtask

    task automatic t_regs;
        logic [31:0] v;
        axr(`SCG_ACD_OFS);
        chk("divider reset", rdat, 32'h0);
        foreach (cnt[k]) begin
            // reserved bits and invalid source and divisor pairs are never written
            v = acd_of(k[0], k, k[1], 5 - k / 2);
            axw(`SCG_ACD_OFS, v);
            axr(`SCG_ACD_OFS);
            chk("divider fields", rdat, v);
        end
        axr(8'h80);
        chk("unmapped read", resp, 32'h2);
        axw(8'h80, 32'h1);
        chk("unmapped write", resp, 32'h2);
    endtask

    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        t_regs();
        for (int k = 0; k < 6; k++) begin
            cfg(ctl_of(1, 8, 1, 0, 0), acd_of(0, k, 1, 2));
            expect_clk(8 * (k + 2), 8 * (k + 2), 8);
        end
        for (int d = 0; d < 6; d++) begin
            cfg(ctl_of(1, 8, 1, 0, 0), acd_of(0, 1, 1, d));
            expect_clk(6 << d, 6 << d, 8);
        end
        cfg(ctl_of(1, 8, 1, 0, 0), acd_of(1, 0, 0, 0));
        expect_clk(4, 32, 8);
        cfg(ctl_of(1, 8, 1, 0, 0), acd_of(0, 2, 0, 3));
        expect_clk(64, 256, 8);
        cfg(ctl_of(1, 16, 2, 0, 1), acd_of(0, 0, 1, 0));
        expect_clk(4, 4, 32);
        cfg(ctl_of(1, 16, 2, 0, 0), acd_of(0, 0, 1, 0));
        expect_clk(4, 4, 16);
        axw(`SCG_ACDD_OFS, 32'h0002_0006);
        cfg(ctl_of(1, 8, 1, 0, 0), acd_of(0, 6, 1, 0));
        expect_clk(6, 6, 8);
        cfg(ctl_of(0, 8, 1, 0, 0), acd_of(1, 0, 1, 2));
        hi = 1'b0;
        repeat (300) @(negedge clk) hi |= sysc;
        chk("system clock idle", hi, 32'h0);
        chk("bit clock core rate", bp, 32'd2);
        cfg(ctl_of(1, 8, 1, 3, 0), acd_of(0, 0, 1, 0));
        expect_clk(4, 8, 8);
        print_verdict();
    end

    initial begin
        repeat (60000) @(posedge clk);
        n_mismatch++;
        print_verdict();
    end

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
endmodule
